// ### hdl/reg_integrity_cfg.svh
`ifndef REG_INTEGRITY_CFG_SVH
`define REG_INTEGRITY_CFG_SVH

// Register offsets on the serial register port.
`define ADDR_STATUS        6'h00
`define ADDR_SETUP         6'h02
`define ADDR_CHECKSUM      6'h03
`define ADDR_RESULT        6'h04

// Interface setup register fields.
`define SETUP_RESET        16'h0000
`define SETUP_WR_MASK      16'h19ed
`define BIT_SHORT_WORD     0
`define BIT_CK_MODE_LO     2
`define BIT_CK_MODE_HI     3
`define BIT_CHECK_ENABLE   5
`define BIT_APPEND_STATUS  6

// Status byte fields.
`define BIT_STAT_READY_N   7
`define BIT_STAT_CONV_ERR  6
`define BIT_STAT_CRC_ERR   5
`define BIT_STAT_REG_ERR   4

// Reset values and checksum constants.
`define CHECKSUM_RESET     24'h000000
`define RESULT_RESET       24'h000000
`define CRC8_POLY          8'h07
`define CRC8_SEED          8'h00

`endif

// ### hdl/reg_integrity_pkg.sv
package reg_integrity_pkg;

    typedef enum logic [1:0] {
        CK_OFF = 2'b00,
        CK_XOR = 2'b01,
        CK_CRC = 2'b10,
        CK_RSV = 2'b11
    } check_mode_t;

    typedef enum logic [0:0] {
        LK_IDLE = 1'b0,
        LK_HELD = 1'b1
    } lock_state_t;

endpackage : reg_integrity_pkg

// ### hdl/register_integrity_and_result_access.sv
`timescale 1ns/1ns
`include "reg_integrity_cfg.svh"

module register_integrity_and_result_access
    import reg_integrity_pkg::*;
#(
    parameter int NUM_MON = 8
) (
    // Clock and reset.
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    // Register access from the serial port.
    input  wire logic                   regWrEn,
    input  wire logic                   regRdEn,
    input  wire logic [5:0]             regAddr,
    input  wire logic [15:0]            regWrData,
    input  wire logic [7:0]             regWrCheck,
    input  wire logic                   frameActive,
    // Read answer.
    output logic                        rdValid,
    output logic [31:0]                 rdData,
    output logic [2:0]                  rdBytes,
    output logic                        rdCheckOn,
    output logic [7:0]                  rdCheck,
    // Converter side.
    input  wire logic                   convValid,
    input  wire logic [23:0]            convData,
    input  wire logic [3:0]             convChannel,
    input  wire logic                   convError,
    input  wire logic                   polaritySelect,
    // Monitored user registers, entry k at bits [24k+23:24k].
    input  wire logic [NUM_MON*24-1:0]  monRegs,
    // Device state.
    output logic                        rdyN,
    output logic [15:0]                 setupWord
);

    // Refuse a monitored-register count that the fold and the bus cannot serve.
    if (NUM_MON < 1 || NUM_MON > 64) begin : g_bad_num_mon
        $error("NUM_MON must be between 1 and 64");
    end

    ////////////////////////////////////////////////////////////////////////////

    function automatic logic [7:0] crc8Byte(input logic [7:0] crc, input logic [7:0] din);
        logic [7:0] c;
        c = crc ^ din;
        for (int b = 0; b < 8; b++) begin
            c = c[7] ? ((c << 1) ^ `CRC8_POLY) : (c << 1);
        end
        return c;
    endfunction : crc8Byte

    // Checksum over the command byte and the low n data bytes, sent MSB first.
    function automatic logic [7:0] frameCheck(input logic       useXor,
                                              input logic [7:0] cmd,
                                              input logic [31:0] data,
                                              input logic [2:0] n);
        logic [7:0] acc;
        logic [7:0] bt;
        acc = useXor ? cmd : crc8Byte(`CRC8_SEED, cmd);
        for (int i = 0; i < 4; i++) begin
            bt = data[8*(3-i) +: 8];
            if (3'(i) >= 3'd4 - n) begin
                acc = useXor ? (acc ^ bt) : crc8Byte(acc, bt);
            end
        end
        return acc;
    endfunction : frameCheck

    ////////////////////////////////////////////////////////////////////////////

    logic [15:0]  setup_reg;
    logic [23:0]  ref_reg;
    logic         refValid_reg;
    logic         regErr_reg;
    logic         crcErr_reg;
    logic [23:0]  result_reg;
    logic         resultShort_reg;
    logic [3:0]   chan_reg;
    logic         convErr_reg;
    logic         rdyN_reg;
    logic [23:0]  pend_reg;
    logic [3:0]   pendChan_reg;
    logic         pendErr_reg;
    logic         pendValid_reg;
    logic         pendShort_reg;
    lock_state_t  lock_reg;
    lock_state_t  lock_next;

    // Fold of the monitored registers; setup, result and status never enter it.
    logic [23:0] xorChain [NUM_MON+1];
    assign xorChain[0] = `CHECKSUM_RESET;
    genvar k;
    generate
        for (k = 0; k < NUM_MON; k++) begin : g_fold
            assign xorChain[k+1] = xorChain[k] ^ monRegs[24*k +: 24];
        end
    endgenerate

    wire          checkEnable  = setup_reg[`BIT_CHECK_ENABLE];
    wire          appendStatus = setup_reg[`BIT_APPEND_STATUS];
    wire          shortWord    = setup_reg[`BIT_SHORT_WORD];
    check_mode_t  ckMode;
    assign ckMode = check_mode_t'(setup_reg[`BIT_CK_MODE_HI:`BIT_CK_MODE_LO]);
    wire          ckActive     = (ckMode == CK_XOR) || (ckMode == CK_CRC);
    wire [23:0]   xorNow       = xorChain[NUM_MON];
    wire [23:0]   checksumRead = checkEnable ? xorNow : `CHECKSUM_RESET;
    wire          mismatch     = checkEnable && refValid_reg && (xorNow != ref_reg);

    ////////////////////////////////////////////////////////////////////////////

    // Write acceptance: when protection is on, writes always carry a CRC byte.
    wire        setupHit   = (regAddr == `ADDR_SETUP);
    wire [7:0]  wrCmd      = {2'b00, regAddr};
    wire [7:0]  wrExpected = frameCheck(1'b0, wrCmd, {16'h0000, regWrData}, 3'd2);
    wire        wrCrcBad   = regWrEn && ckActive && (regWrCheck != wrExpected);
    wire        setupWrite = regWrEn && setupHit && !wrCrcBad;
    wire [15:0] setupNext  = regWrData & `SETUP_WR_MASK;
    wire        enableOff  = setupWrite && !setupNext[`BIT_CHECK_ENABLE];

    // Result coding and width as seen at load time.
    wire [23:0] codedBip   = {~convData[23], convData[22:0]};
    wire [23:0] codedUni   = convData[23] ? 24'h000000 : {convData[22:0], 1'b0};
    wire [23:0] codedFull  = polaritySelect ? codedUni : codedBip;
    wire [23:0] codedWord  = shortWord ? {8'h00, codedFull[23:8]} : codedFull;

    // Result lock around a read of the result register.
    wire        resultRead = regRdEn && (regAddr == `ADDR_RESULT);
    wire        unlocked   = (lock_reg == LK_IDLE) && !resultRead;
    wire        loadFresh  = convValid && unlocked;
    wire        loadPend   = !convValid && pendValid_reg && unlocked;
    wire        loadAny    = loadFresh || loadPend;
    wire        holdConv   = convValid && !unlocked;
    wire        statusRead = regRdEn && (regAddr == `ADDR_STATUS);

    always_comb begin
        lock_next = lock_reg;
        case (lock_reg)
            LK_IDLE: begin
                if (resultRead) begin
                    lock_next = LK_HELD;
                end
            end
            LK_HELD: begin
                if (!frameActive && !resultRead) begin
                    lock_next = LK_IDLE;
                end
            end
            default: begin
                lock_next = LK_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////

    // Read answer assembly.
    wire [7:0]  statusByte = {rdyN_reg, convErr_reg, crcErr_reg, regErr_reg, chan_reg};
    wire [23:0] resultWord = resultShort_reg ? {8'h00, result_reg[15:0]} : result_reg;
    wire [2:0]  resultLen  = resultShort_reg ? 3'd2 : 3'd3;
    logic [31:0] ansData;
    logic [2:0]  ansLen;

    always_comb begin
        ansData = 32'h00000000;
        ansLen  = 3'd1;
        case (regAddr)
            `ADDR_STATUS: begin
                ansData = {24'h000000, statusByte};
                ansLen  = 3'd1;
            end
            `ADDR_SETUP: begin
                ansData = {16'h0000, setup_reg};
                ansLen  = 3'd2;
            end
            `ADDR_CHECKSUM: begin
                ansData = {8'h00, checksumRead};
                ansLen  = 3'd3;
            end
            `ADDR_RESULT: begin
                if (appendStatus) begin
                    ansData = resultShort_reg ? {8'h00, resultWord[15:0], statusByte}
                                              : {resultWord, statusByte};
                    ansLen  = resultLen + 3'd1;
                end else begin
                    ansData = {8'h00, resultWord};
                    ansLen  = resultLen;
                end
            end
            default: begin
                ansData = 32'h00000000;
                ansLen  = 3'd1;
            end
        endcase
    end

    wire [7:0] rdCmd   = {2'b01, regAddr};
    wire [7:0] ansChk  = frameCheck(ckMode == CK_XOR, rdCmd, ansData, ansLen);

    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            setup_reg <= `SETUP_RESET;
        end else if (setupWrite) begin
            setup_reg <= setupNext;
        end
    end

    // Reference is taken one cycle after enable; the host must have finished
    // configuration by then, or the reference captures a half-set map.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ref_reg      <= `CHECKSUM_RESET;
            refValid_reg <= 1'b0;
        end else if (!checkEnable) begin
            ref_reg      <= `CHECKSUM_RESET;
            refValid_reg <= 1'b0;
        end else if (!refValid_reg) begin
            ref_reg      <= xorNow;
            refValid_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            regErr_reg <= 1'b0;
        end else if (mismatch) begin
            regErr_reg <= 1'b1;
        end else if (enableOff || !checkEnable) begin
            regErr_reg <= 1'b0;
        end
    end

    // A CRC failure in the same cycle as a status read stays set.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            crcErr_reg <= 1'b0;
        end else if (wrCrcBad) begin
            crcErr_reg <= 1'b1;
        end else if (statusRead) begin
            crcErr_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lock_reg <= LK_IDLE;
        end else begin
            lock_reg <= lock_next;
        end
    end

    // A result arriving during a locked read waits here, coded at arrival.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pend_reg      <= `RESULT_RESET;
            pendChan_reg  <= 4'h0;
            pendErr_reg   <= 1'b0;
            pendValid_reg <= 1'b0;
            pendShort_reg <= 1'b0;
        end else if (holdConv) begin
            pend_reg      <= codedWord;
            pendShort_reg <= shortWord;
            pendChan_reg  <= convChannel;
            pendErr_reg   <= convError;
            pendValid_reg <= 1'b1;
        end else if (loadPend) begin
            pendValid_reg <= 1'b0;
        end
    end

    // Width is latched with each result so a setup write never reshapes it.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            result_reg      <= `RESULT_RESET;
            resultShort_reg <= 1'b0;
            chan_reg        <= 4'h0;
            convErr_reg     <= 1'b0;
        end else if (loadFresh) begin
            result_reg      <= codedWord;
            resultShort_reg <= shortWord;
            chan_reg        <= convChannel;
            convErr_reg     <= convError;
        end else if (loadPend) begin
            result_reg      <= pend_reg;
            resultShort_reg <= pendShort_reg;
            chan_reg        <= pendChan_reg;
            convErr_reg     <= pendErr_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdyN_reg <= 1'b1;
        end else if (resultRead) begin
            rdyN_reg <= 1'b1;
        end else if (loadAny) begin
            rdyN_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdValid   <= 1'b0;
            rdData    <= 32'h00000000;
            rdBytes   <= 3'd0;
            rdCheckOn <= 1'b0;
            rdCheck   <= 8'h00;
        end else begin
            rdValid   <= regRdEn;
            rdData    <= regRdEn ? ansData : rdData;
            rdBytes   <= regRdEn ? ansLen : rdBytes;
            rdCheckOn <= regRdEn ? ckActive : rdCheckOn;
            rdCheck   <= regRdEn ? (ckActive ? ansChk : 8'h00) : rdCheck;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdyN      <= 1'b1;
            setupWord <= `SETUP_RESET;
        end else begin
            rdyN      <= (resultRead || (rdyN_reg && !loadAny)) ? 1'b1 : 1'b0;
            setupWord <= setupWrite ? setupNext : setup_reg;
        end
    end

endmodule : register_integrity_and_result_access

// ### verification/reg_host_model.sv
`timescale 1ns/1ns
module reg_host_model (
    // Clock.
    input  wire logic        clk_sys,
    // Requests.
    output logic             regWrEn,
    output logic             regRdEn,
    output logic [5:0]       regAddr,
    output logic [15:0]      regWrData,
    output logic [7:0]       regWrCheck,
    output logic             frameActive,
    // Answers.
    input  wire logic        rdValid,
    input  wire logic [31:0] rdData,
    input  wire logic [2:0]  rdBytes,
    input  wire logic        rdCheckOn,
    input  wire logic [7:0]  rdCheck
);
    logic        holdFrame = 1'b0;
    logic        corrupt = 1'b0;
    logic        rValid;
    logic [31:0] rData;
    logic [2:0]  rBytes;
    logic        rChkOn;
    logic [7:0]  rChk;
    initial begin
        {regWrEn, regRdEn, regAddr, regWrData, regWrCheck, frameActive} = '0;
    end
    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction : crc8
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regWrEn     <= 1'b1;
        regAddr     <= a;
        regWrData   <= d;
        regWrCheck  <= crc8({2'b00, a, d}) ^ (corrupt ? 8'hff : 8'h00);
        frameActive <= 1'b1;
        @(posedge clk_sys);
        regWrEn     <= 1'b0;
        regWrData   <= ~d;
        frameActive <= holdFrame;
    endtask : wr
    task automatic rd(input logic [5:0] a);
        @(posedge clk_sys);
        regRdEn     <= 1'b1;
        regAddr     <= a;
        frameActive <= 1'b1;
        @(posedge clk_sys);
        regRdEn     <= 1'b0;
        frameActive <= holdFrame;
        #1;
        {rValid, rData, rBytes, rChkOn, rChk} = {rdValid, rdData, rdBytes, rdCheckOn, rdCheck};
    endtask : rd
    task automatic release_frame;
        @(posedge clk_sys);
        holdFrame = 1'b0;
        frameActive <= 1'b0;
    endtask : release_frame
endmodule : reg_host_model

// ### verification/register_integrity_and_result_access_monitor.sv
`timescale 1ns/1ns
`include "reg_integrity_cfg.svh"
module reg_integrity_monitor
    import reg_integrity_pkg::*;
#(
    parameter int NUM_MON = 8
) (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Requests.
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    input  wire logic [5:0]  regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        frameActive,
    input  wire logic        convValid,
    // Answers.
    input  wire logic        rdValid,
    input  wire logic [31:0] rdData,
    input  wire logic [2:0]  rdBytes,
    input  wire logic        rdCheckOn,
    input  wire logic [7:0]  rdCheck,
    input  wire logic        rdyN,
    input  wire logic [15:0] setupWord
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire rdRes  = regRdEn && regAddr == `ADDR_RESULT;
    wire wrOpen = regWrEn && regAddr == `ADDR_SETUP && setupWord[3:2] == 2'b00;
    sequence sLoad;
        !frameActive ##1 convValid && !frameActive && !regRdEn ##1 !regRdEn;
    endsequence
    ////////////////////////////////////////////////////////////
    AST_RDY_HIGH: assert property (rdRes |=> rdyN) else $error("ready not high");
    AST_RDY_FALL: assert property (sLoad |=> !rdyN) else $error("ready not low");
    AST_RD_PULSE: assert property (regRdEn |=> rdValid ##1 rdValid == $past(regRdEn))
        else $error("read answer timing wrong");
    AST_RD_HOLD: assert property (!regRdEn |=> $stable(rdData)) else $error("data moved");
    AST_CK_ZERO: assert property (regRdEn && regAddr == `ADDR_CHECKSUM && !setupWord[5]
        |=> rdData == 32'h00000000) else $error("checksum not zero");
    AST_APPEND: assert property (rdRes && setupWord[6] |=> rdBytes >= 3'h3)
        else $error("append byte count low");
    AST_CK_ON: assert property (regRdEn && ^setupWord[3:2] |=> rdCheckOn)
        else $error("checksum byte missing");
    AST_CK_OFF: assert property (regRdEn && setupWord[3:2] == 2'b00
        |=> !rdCheckOn && rdCheck == 8'h00) else $error("checksum byte unexpected");
    AST_SETUP_WR: assert property (wrOpen
        |=> setupWord == ($past(regWrData) & `SETUP_WR_MASK)) else $error("setup write lost");
endmodule : reg_integrity_monitor

bind register_integrity_and_result_access reg_integrity_monitor #(.NUM_MON(NUM_MON)) mon (
    .clk_sys(clk_sys), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .frameActive(frameActive),
    .convValid(convValid), .rdValid(rdValid), .rdData(rdData), .rdBytes(rdBytes),
    .rdCheckOn(rdCheckOn), .rdCheck(rdCheck), .rdyN(rdyN), .setupWord(setupWord));

// ### verification/register_integrity_and_result_access_tb.sv
`timescale 1ns/1ns
module register_integrity_and_result_access_tb;
    import reg_integrity_pkg::*;
    localparam int NUM_MON = 2;
    logic                 clk_sys = 1'b0;
    logic                 rst_n = 1'b0;
    logic                 regWrEn, regRdEn, frameActive, rdValid, rdCheckOn, rdyN;
    logic [5:0]           regAddr;
    logic [15:0]          regWrData, setupWord;
    logic [7:0]           regWrCheck, rdCheck;
    logic [31:0]          rdData;
    logic [2:0]           rdBytes;
    logic                 convValid = 1'b0, polaritySelect = 1'b0, convError = 1'b0;
    logic [23:0]          convData = 24'h000000;
    logic [3:0]           convChannel = 4'h0;
    logic [NUM_MON*24-1:0] monRegs = '0;
    int                   miscompares = 0, num_checks = 0, cyc = 0;
    always #25 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////
    reg_host_model host (.clk_sys(clk_sys), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regWrCheck(regWrCheck),
        .frameActive(frameActive), .rdValid(rdValid), .rdData(rdData), .rdBytes(rdBytes),
        .rdCheckOn(rdCheckOn), .rdCheck(rdCheck));
    register_integrity_and_result_access #(.NUM_MON(NUM_MON)) dut (.clk_sys(clk_sys),
        .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
        .regWrData(regWrData), .regWrCheck(regWrCheck), .frameActive(frameActive),
        .rdValid(rdValid), .rdData(rdData), .rdBytes(rdBytes), .rdCheckOn(rdCheckOn),
        .rdCheck(rdCheck), .convValid(convValid), .convData(convData),
        .convChannel(convChannel), .convError(convError), .polaritySelect(polaritySelect),
        .monRegs(monRegs), .rdyN(rdyN), .setupWord(setupWord));
    ////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic rdx(input logic [5:0] a, input logic [31:0] exp);
        host.rd(a);
        chk("rdValid", 32'h1, host.rValid);
        chk("rdData", exp, host.rData);
    endtask : rdx
    task automatic conv(input logic [23:0] d, input logic p, input logic [3:0] ch);
        @(posedge clk_sys);
        {convValid, convData, polaritySelect, convChannel} <= {1'b1, d, p, ch};
        @(posedge clk_sys);
        convValid <= 1'b0;
        convData  <= ~d;
        repeat (3) @(posedge clk_sys);
    endtask : conv
    function automatic logic [23:0] code(input logic [23:0] d, input logic p);
        return p ? (d[23] ? 24'h000000 : {d[22:0], 1'b0}) : {~d[23], d[22:0]};
    endfunction : code
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        rdx(6'h02, 32'h0);
        rdx(6'h03, 32'h0);
        rdx(6'h04, 32'h0);
        chk("rdyN", 32'h1, rdyN);
        monRegs <= {24'h123456, 24'h0f0f0f};
        host.wr(6'h02, 16'h0020);
        rdx(6'h03, 24'h123456 ^ 24'h0f0f0f);
        host.wr(6'h02, 16'h0021);
        repeat (3) @(posedge clk_sys);
        host.rd(6'h00);
        chk("regError", 32'h0, host.rData[4]);
        monRegs[23:0] <= 24'h0f0f0e;
        repeat (3) @(posedge clk_sys);
        host.rd(6'h00);
        chk("regError", 32'h1, host.rData[4]);
        host.wr(6'h02, 16'h0000);
        host.rd(6'h00);
        chk("regError", 32'h0, host.rData[4]);
        rdx(6'h03, 32'h0);
        conv(24'h812345, 1'b0, 4'h3);
        chk("rdyN", 32'h0, rdyN);
        rdx(6'h04, code(24'h812345, 1'b0));
        chk("rdyN", 32'h1, rdyN);
        rdx(6'h04, code(24'h812345, 1'b0));
        host.holdFrame = 1'b1;
        host.rd(6'h04);
        conv(24'h000100, 1'b1, 4'h5);
        rdx(6'h04, code(24'h812345, 1'b0));
        host.release_frame();
        repeat (4) @(posedge clk_sys);
        rdx(6'h04, code(24'h000100, 1'b1));
        host.wr(6'h02, 16'h0001);
        rdx(6'h04, code(24'h000100, 1'b1));
        chk("rdBytes", 32'h3, host.rBytes);
        conv(24'h7fff00, 1'b0, 4'h6);
        rdx(6'h04, code(24'h7fff00, 1'b0) >> 8);
        chk("rdBytes", 32'h2, host.rBytes);
        conv(24'h800001, 1'b1, 4'h6);
        rdx(6'h04, 32'h0);
        host.wr(6'h02, 16'h0040);
        convError <= 1'b1;
        conv(24'h000001, 1'b0, 4'h9);
        convError <= 1'b0;
        host.rd(6'h04);
        chk("rdBytes", 32'h4, host.rBytes);
        chk("rdData", code(24'h000001, 1'b0), host.rData >> 8);
        chk("channel", 32'h9, host.rData[3:0]);
        chk("status", 32'h49, host.rData[7:0]);
        host.wr(6'h02, 16'h0004);
        rdx(6'h02, 32'h4);
        chk("rdCheckOn", 32'h1, host.rChkOn);
        chk("rdCheck", 8'h42 ^ 8'h00 ^ 8'h04, host.rChk);
        host.wr(6'h02, 16'h0008);
        rdx(6'h02, 32'h8);
        chk("rdCheckOn", 32'h1, host.rChkOn);
        chk("rdCheck", host.crc8({8'h42, 16'h0008}), host.rChk);
        host.corrupt = 1'b1;
        host.wr(6'h02, 16'h0001);
        host.corrupt = 1'b0;
        host.rd(6'h00);
        chk("crcError", 32'h1, host.rData[5]);
        host.rd(6'h00);
        chk("crcError", 32'h0, host.rData[5]);
        rdx(6'h02, 32'h8);
        host.wr(6'h02, 16'h0000);
        rdx(6'h02, 32'h0);
        chk("rdCheckOn", 32'h0, host.rChkOn);
        host.wr(6'h02, 16'h000c);
        rdx(6'h02, 32'hc);
        chk("rdCheckOn", 32'h0, host.rChkOn);
        chk("rdCheck", 32'h0, host.rChk);
        rdx(6'h3f, 32'h0);
        chk("rdBytes", 32'h1, host.rBytes);
        tally_and_finish();
    end
endmodule : register_integrity_and_result_access_tb
